// ==== dv/osc_control_unlock_regs_asserts.sv ====
// Purpose: Port-level checks of the oscillator control block
// Assumes: Config word changes only while reset is held
// Notes: Bound to every osc_control_unlock_regs instance
`timescale 1ns/1ps
module osc_control_unlock_regs_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic [23:0] cfg_word_in,
    input wire logic pll_lock_in,
    input wire logic clk_fail_in,
    input wire logic switch_done_in,
    input wire osc_ctrl_pkg::clk_sel_s clk_sel,
    input wire logic switch_enabled,
    input wire logic monitor_enabled,
    input wire logic sys_clk_en
);
// ====================
// Cycles since reset release
logic [2:0] age_q;
logic [2:0] age_d;
wire logic ready = age_q == 3'h7;
wire logic ctl_rd = psel && penable && !pwrite && paddr == 12'h000;
assign age_d = ready ? age_q : age_q + 3'h1;
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        age_q <= 3'h0;
    end else begin
        age_q <= age_d;
    end
end
// ====================
// Properties
default clocking cb @(posedge pclk);
endclocking
default disable iff (!presetn);
property p_unimpl;
    ctl_rd |-> prdata[31:15] == 17'h0 && prdata[11] == 1'b0
        && prdata[4] == 1'b0 && prdata[2] == 1'b0;
endproperty
a_unimpl: assert property (p_unimpl)
    else $error("unimplemented control bit read high");
property p_lock;
    $stable(pll_lock_in) [*5] ##1 ctl_rd && $stable(pll_lock_in)
        |-> prdata[5] == pll_lock_in;
endproperty
a_lock: assert property (p_lock)
    else $error("lock bit differs from lock input");
property p_cfg_en;
    ready |-> switch_enabled == !cfg_word_in[15]
        && monitor_enabled == (cfg_word_in[15:14] == 2'b00);
endproperty
a_cfg_en: assert property (p_cfg_en)
    else $error("switch or monitor enable wrong");
property p_pri;
    ready |-> clk_sel.primary_osc_select == cfg_word_in[4:0];
endproperty
a_pri: assert property (p_pri)
    else $error("primary option differs from config");
property p_fixed;
    ready && !switch_enabled
        |-> clk_sel.group == cfg_word_in[10:8] && !clk_sel.switch_start;
endproperty
a_fixed: assert property (p_fixed)
    else $error("group not taken from config");
property p_fail;
    $rose(clk_fail_in) && monitor_enabled
        |-> ##[1:6] (clk_sel.group == 3'h1 && !clk_sel.switch_start);
endproperty
a_fail: assert property (p_fail)
    else $error("failure did not select fast RC");
property p_done;
    $rose(switch_done_in) && clk_sel.switch_start && !clk_fail_in
        |-> ##[1:6] !clk_sel.switch_start;
endproperty
a_done: assert property (p_done)
    else $error("switch did not complete");
property p_pace;
    sys_clk_en |=> ##[0:63] sys_clk_en;
endproperty
a_pace: assert property (p_pace)
    else $error("clock enable gap above 64");
endmodule
bind osc_control_unlock_regs osc_control_unlock_regs_asserts chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .cfg_word_in(cfg_word_in), .pll_lock_in(pll_lock_in),
    .clk_fail_in(clk_fail_in), .switch_done_in(switch_done_in),
    .clk_sel(clk_sel), .switch_enabled(switch_enabled),
    .monitor_enabled(monitor_enabled), .sys_clk_en(sys_clk_en)
);

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench of the oscillator control block
// Assumes: Zero wait APB slave, config static between resets
// Notes: Random values from a fixed xorshift seed
`timescale 1ns/1ps
module testbench;
logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, rdata, seed;
logic [3:0] pstrb;
logic [23:0] cfg_word_in, cfg;
logic pll_lock_in, clk_fail_in, switch_done_in, s;
logic switch_enabled, monitor_enabled, sys_clk_en;
osc_ctrl_pkg::clk_sel_s sel;
logic [2:0] grp [5];
logic [2:0] g, x;
logic [1:0] p;
int failures, check_count, n, i;
osc_control_unlock_regs uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_word_in(cfg_word_in), .pll_lock_in(pll_lock_in),
    .clk_fail_in(clk_fail_in), .switch_done_in(switch_done_in),
    .clk_sel(sel), .switch_enabled(switch_enabled),
    .monitor_enabled(monitor_enabled), .sys_clk_en(sys_clk_en)
);
// ====================
// Helpers
function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
endfunction
function automatic logic [31:0] ctl(input logic [2:0] c, input logic [2:0] k,
    input logic [1:0] d, input logic f, input logic e, input logic q);
    return {16'h0000, 1'b0, c, 1'b0, k, d, 2'b00, f, 1'b0, e, q};
endfunction
task final_report();
    $display("failures=%0d checks=%0d", failures, check_count);
    if (failures == 0 && check_count > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
task tmo();
    failures++;
    final_report();
endtask
task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
        failures++;
        $display("Error %s expected %h seen %h", nm, exp, seen);
    end
endtask
task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] b);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= b;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
        @(posedge pclk);
        k++;
    end
    if (pready !== 1'b1) tmo();
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
endtask
task automatic lk(input logic h, input logic [7:0] v);
    logic [3:0] b;
    b = h ? 4'h2 : 4'h1;
    apb(1'b1, 12'h000, {4{h ? 8'h78 : 8'h46}}, b);
    apb(1'b1, 12'h000, {4{h ? 8'h9A : 8'h57}}, b);
    apb(1'b1, 12'h000, {4{v}}, b);
endtask
task automatic wt(input logic v);
    int k;
    k = 0;
    while (sel.switch_start !== v && k < 20) begin
        @(posedge pclk);
        k++;
    end
    if (sel.switch_start !== v) tmo();
endtask
task automatic pm(output int q);
    int k;
    k = 0;
    while (sys_clk_en !== 1'b1 && k < 99) begin
        @(posedge pclk);
        k++;
    end
    if (sys_clk_en !== 1'b1) tmo();
    @(posedge pclk);
    q = 1;
    while (sys_clk_en !== 1'b1 && q < 99) begin
        @(posedge pclk);
        q++;
    end
endtask
task automatic rst(input logic [23:0] c);
    presetn <= 1'b0;
    cfg_word_in <= c;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
endtask
// ====================
// Clock and sequence
initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
end
initial begin
    {presetn, psel, penable, pwrite, pll_lock_in} = 5'h00;
    {clk_fail_in, switch_done_in} = 2'h0;
    {paddr, pwdata, pstrb, cfg_word_in} = '0;
    failures = 0;
    check_count = 0;
    seed = 32'h322D618E;
    grp = '{3'h7, 3'h3, 3'h2, 3'h1, 3'h0};
    @(posedge pclk);
    cfg = 24'h008305;
    rst(cfg);
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    chk("ctl", rdata, ctl(3'h3, 3'h3, 2'h0, 1'b0, 1'b0, 1'b0));
    apb(1'b0, 12'h004, 32'h0, 4'h0);
    chk("trim", rdata, 32'h0);
    apb(1'b0, 12'h008, 32'h0, 4'h0);
    chk("cfg", rdata, {8'h00, cfg});
    apb(1'b0, 12'h00C, 32'h0, 4'h0);
    chk("unmapped", rerr, 1'b1);
    chk("enables", {switch_enabled, monitor_enabled}, 2'b00);
    lk(1'b0, 8'h01);
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    chk("ctl", rdata, ctl(3'h3, 3'h3, 2'h0, 1'b0, 1'b0, 1'b0));
    chk("group", sel.group, 3'h3);
    seed = xs(seed);
    g = grp[seed % 5];
    cfg = {8'h00, 2'b00, 3'b000, g, 3'b000, seed[12:8]};
    rst(cfg);
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    chk("ctl", rdata, ctl(g, g, 2'h0, 1'b0, 1'b0, 1'b0));
    chk("enables", {switch_enabled, monitor_enabled}, 2'b11);
    apb(1'b1, 12'h000, 32'hFFFFFFFF, 4'hF);
    apb(1'b1, 12'h000, 32'h46, 4'h1);
    apb(1'b0, 12'h004, 32'h0, 4'h0);
    apb(1'b1, 12'h000, 32'h57, 4'h1);
    apb(1'b1, 12'h000, 32'hC2, 4'h1);
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    chk("ctl", rdata, ctl(g, g, 2'h0, 1'b0, 1'b0, 1'b0));
    for (i = 0; i < 4; i++) begin
        p = i[1:0];
        seed = xs(seed);
        s = seed[0];
        lk(1'b0, {p, 4'hF, s, 1'b0});
        apb(1'b0, 12'h000, 32'h0, 4'h0);
        chk("ctl", rdata, ctl(g, g, p, 1'b0, s, 1'b0));
        chk("sosc", sel.secondary_osc_enable, s);
        pm(n);
        pm(n);
        chk("period", n, 1 << (2 * i));
    end
    apb(1'b1, 12'h000, 32'h0, 4'h1);
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    chk("ctl", rdata, ctl(g, g, p, 1'b0, s, 1'b0));
    for (i = 0; i < 5; i++) begin
        lk(1'b1, {1'b1, ~g, 1'b1, grp[i]});
        apb(1'b0, 12'h000, 32'h0, 4'h0);
        chk("ctl", rdata, ctl(g, grp[i], p, 1'b0, s, 1'b0));
    end
    seed = xs(seed);
    x = grp[seed % 5];
    lk(1'b1, {5'h00, x});
    lk(1'b0, {p, 4'h0, s, 1'b1});
    wt(1'b1);
    chk("group", sel.group, x);
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    chk("ctl", rdata, ctl(g, x, p, 1'b0, s, 1'b1));
    switch_done_in <= 1'b1;
    wt(1'b0);
    switch_done_in <= 1'b0;
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    chk("ctl", rdata, ctl(x, x, p, 1'b0, s, 1'b0));
    chk("option", sel.primary_osc_select, cfg[4:0]);
    g = x;
    x = (g == 3'h7) ? 3'h2 : 3'h7;
    lk(1'b1, {5'h00, x});
    lk(1'b0, {p, 4'h0, s, 1'b1});
    wt(1'b1);
    lk(1'b0, {p, 4'h0, s, 1'b0});
    wt(1'b0);
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    chk("ctl", rdata, ctl(g, x, p, 1'b0, s, 1'b0));
    chk("group", sel.group, g);
    lk(1'b0, {p, 4'h0, s, 1'b1});
    wt(1'b1);
    clk_fail_in <= 1'b1;
    repeat (6) @(posedge pclk);
    clk_fail_in <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    chk("ctl", rdata, ctl(3'h1, x, p, 1'b1, s, 1'b0));
    lk(1'b0, {p, 4'h0, s, 1'b0});
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    chk("ctl", rdata, ctl(3'h1, x, p, 1'b0, s, 1'b0));
    for (i = 1; i >= 0; i--) begin
        pll_lock_in <= i[0];
        repeat (6) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0, 4'h0);
        chk("lock", rdata[5], i[0]);
    end
    for (i = 0; i < 3; i++) begin
        seed = xs(seed);
        apb(1'b1, 12'h004, seed, 4'hF);
        apb(1'b0, 12'h004, 32'h0, 4'h0);
        chk("trim", rdata, {28'h0, seed[3:0]});
        chk("trim_out", sel.fast_rc_trim, seed[3:0]);
    end
    cfg[15:14] = 2'b01;
    x = cfg[10:8];
    rst(cfg);
    chk("enables", {switch_enabled, monitor_enabled}, 2'b10);
    clk_fail_in <= 1'b1;
    repeat (6) @(posedge pclk);
    clk_fail_in <= 1'b0;
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    chk("ctl", rdata, ctl(x, x, 2'h0, 1'b0, 1'b0, 1'b0));
    final_report();
end
endmodule

// ==== hdl/osc_control_unlock_regs.sv ====
// Purpose: Protected oscillator control, trim and configuration regs
// Assumes: APB4 slave, zero wait states, fuse word is static
// Notes: Pin inputs pass two flip-flops before use
//
// Notes on behaviour
// - Low byte accepts an update only after writes 0x46 then 0x57.
// - High byte accepts an update only after writes 0x78 then 0x9A.
// - After the key pair, exactly one following access may write.
// - Current group sits in bits 14-12 and is read-only.
// - After reset release, current and next groups load the power-on group.
// - A completed switch copies the next group into current group.
// - A clock failure forces the fast RC code into current group.
// - Next group sits in bits 10-8, readable and writable.
// - Postscaler bits 7-6 divide by 1, 4, 16 or 64; reset zero.
// - Lock bit 5 is read-only, mirrors PLL lock, resets zero.
// - Fail flag bit 3 is set by the monitor, cleared by software.
// - Bit 1 enables the secondary oscillator; resets zero.
// - Bit 0 requests a switch; hardware clears it when done.
// - Bits 15, 11, 4 and 2 read zero and ignore writes.
// - Trim field bits 3-0 resets zero; upper bits read zero.
// - Config bits 15-14: 1x none, 01 switching, 00 both.
// - Config bits 10-8 give the power-on clock group.
// - Config bits 4-0 choose the option inside the primary group.
// - Clearing the request during a switch aborts it.
// - A failure sets current to fast RC, sets flag, clears request.
// - Switches move between groups; primary option comes from config.
// - With switching off, config selects; current group only reflects.
`timescale 1ns/1ps
`include "osc_ctrl_cfg.svh"
module osc_control_unlock_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [23:0] cfg_word_in,
    input wire logic pll_lock_in,
    input wire logic clk_fail_in,
    input wire logic switch_done_in,
    output osc_ctrl_pkg::clk_sel_s clk_sel,
    output logic switch_enabled,
    output logic monitor_enabled,
    output logic sys_clk_en
);
    // ======================================================
    // Pin synchronisers
    logic [26:0] sync1_q;
    logic [26:0] sync2_q;
    logic done_prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 27'h0000000;
            sync2_q <= 27'h0000000;
        end else begin
            sync1_q <= {cfg_word_in, pll_lock_in, clk_fail_in,
                        switch_done_in};
            sync2_q <= sync1_q;
        end
    end

    wire [23:0] cfg_sync = sync2_q[26:3];
    wire lock_sync = sync2_q[2];
    wire fail_sync = sync2_q[1];
    wire done_sync = sync2_q[0];

    // ======================================================
    // Configuration capture after reset release
    logic [1:0] settle_q;
    logic [23:0] cfg_q;
    wire settled = (settle_q == `SYNC_SETTLE);
    wire init_load = (settle_q == `SYNC_SETTLE - 2'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_q <= 2'h0;
        end else if (!settled) begin
            settle_q <= settle_q + 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= `CFG_RST;
        end else if (init_load) begin
            cfg_q <= cfg_sync;
        end
    end

    wire [1:0] swmon_cfg = cfg_q[`SWMON_LSB +: 2];
    wire [2:0] pon_group = cfg_q[`PON_GRP_LSB +: 3];
    wire [4:0] pri_select = cfg_q[`PRI_SEL_LSB +: 5];
    wire sw_on = settled && !swmon_cfg[1];
    wire mon_on = settled && (swmon_cfg == 2'h0);

    // ======================================================
    // APB decode
    wire access = psel && penable;
    wire wr_acc = access && pwrite;
    wire sel_ctrl = (paddr == `OSC_CTRL_OFS);
    wire sel_trim = (paddr == `FRC_TRIM_OFS);
    wire sel_cfg = (paddr == `OSC_CFG_OFS);
    wire mapped = sel_ctrl || sel_trim || sel_cfg;
    wire ctrl_lo_wr = wr_acc && sel_ctrl && pstrb[0];
    wire ctrl_hi_wr = wr_acc && sel_ctrl && pstrb[1];
    wire trim_wr = wr_acc && sel_trim && pstrb[0];
    logic lo_commit;
    logic hi_commit;

    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // ======================================================
    // Unlock sequences for the low and high byte lanes
    osc_unlock_seq #(
        .KEY1(`LO_KEY1),
        .KEY2(`LO_KEY2)
    ) u_lo_unlock (
        .pclk(pclk),
        .presetn(presetn),
        .access(access),
        .lane_write(ctrl_lo_wr),
        .lane_data(pwdata[7:0]),
        .commit(lo_commit)
    );

    osc_unlock_seq #(
        .KEY1(`HI_KEY1),
        .KEY2(`HI_KEY2)
    ) u_hi_unlock (
        .pclk(pclk),
        .presetn(presetn),
        .access(access),
        .lane_write(ctrl_hi_wr),
        .lane_data(pwdata[15:8]),
        .commit(hi_commit)
    );

    // ======================================================
    // Clock switch sequencer
    osc_ctrl_pkg::osc_ctrl_s ctl_q, ctl_d;
    osc_ctrl_pkg::switch_e sw_q, sw_d;
    logic [3:0] trim_q;
    logic lock_q;

    wire done_pulse = done_sync && !done_prev_q;
    wire fail_event = mon_on && fail_sync;
    wire req_clear_wr = lo_commit && !pwdata[`REQ_BIT];
    wire req_set_wr = lo_commit && pwdata[`REQ_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_prev_q <= 1'b0;
        end else begin
            done_prev_q <= done_sync;
        end
    end

    always_comb begin
        sw_d = sw_q;
        case (sw_q)
            osc_ctrl_pkg::SW_IDLE: begin
                if (ctl_q.clk_switch_request && sw_on && !fail_event) begin
                    sw_d = osc_ctrl_pkg::SW_BUSY;
                end
            end
            default: begin
                if (fail_event || req_clear_wr || !sw_on) begin
                    sw_d = osc_ctrl_pkg::SW_IDLE;
                end else if (done_pulse) begin
                    sw_d = osc_ctrl_pkg::SW_IDLE;
                end
            end
        endcase
    end

    wire sw_complete = (sw_q == osc_ctrl_pkg::SW_BUSY) && done_pulse
                       && !fail_event && !req_clear_wr && sw_on;

    // ======================================================
    // Control register next value
    always_comb begin
        ctl_d = ctl_q;
        if (init_load) begin
            ctl_d.current_clk_group = cfg_sync[`PON_GRP_LSB +: 3];
            ctl_d.next_clk_group = cfg_sync[`PON_GRP_LSB +: 3];
        end
        if (hi_commit) begin
            ctl_d.next_clk_group = pwdata[`NXT_GRP_LSB +: 3];
        end
        if (lo_commit) begin
            ctl_d.clk_postscale_sel = pwdata[`POST_LSB +: 2];
            ctl_d.secondary_osc_enable = pwdata[`SOSC_BIT];
            if (!pwdata[`CF_BIT]) begin
                ctl_d.clk_fail_flag = 1'b0;
            end
            ctl_d.clk_switch_request = req_set_wr && sw_on;
        end
        if (settled && !sw_on) begin
            ctl_d.current_clk_group = pon_group;
            ctl_d.clk_switch_request = 1'b0;
        end
        if (sw_complete) begin
            ctl_d.current_clk_group = ctl_q.next_clk_group;
            ctl_d.clk_switch_request = 1'b0;
        end
        if (fail_event) begin
            ctl_d.current_clk_group = `GRP_FRC;
            ctl_d.clk_fail_flag = 1'b1;
            ctl_d.clk_switch_request = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= '{current_clk_group: `GRP_RST,
                       next_clk_group: `GRP_RST,
                       clk_postscale_sel: `POST_RST,
                       clk_fail_flag: 1'b0,
                       secondary_osc_enable: 1'b0,
                       clk_switch_request: 1'b0};
            sw_q <= osc_ctrl_pkg::SW_IDLE;
        end else begin
            ctl_q <= ctl_d;
            sw_q <= sw_d;
        end
    end

    // ======================================================
    // Trim register and lock status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_q <= `TRIM_RST;
            lock_q <= 1'b0;
        end else begin
            if (trim_wr) begin
                trim_q <= pwdata[3:0];
            end
            lock_q <= lock_sync;
        end
    end

    // ======================================================
    // Read data assembly
    function automatic logic [31:0] ctrl_word(
        input osc_ctrl_pkg::osc_ctrl_s c,
        input logic lock
    );
        logic [31:0] w;
        w = 32'h00000000;
        w[`CUR_GRP_LSB +: 3] = c.current_clk_group;
        w[`NXT_GRP_LSB +: 3] = c.next_clk_group;
        w[`POST_LSB +: 2] = c.clk_postscale_sel;
        w[`LOCK_BIT] = lock;
        w[`CF_BIT] = c.clk_fail_flag;
        w[`SOSC_BIT] = c.secondary_osc_enable;
        w[`REQ_BIT] = c.clk_switch_request;
        return w;
    endfunction

    wire [31:0] ctrl_rd = ctrl_word(ctl_q, lock_q);
    wire [31:0] trim_rd = {28'h0000000, trim_q};
    wire [31:0] cfg_rd = {16'h0000, cfg_q[15:14], 3'h0, cfg_q[10:8],
                          3'h0, cfg_q[4:0]};
    wire [31:0] rd_mux = sel_ctrl ? ctrl_rd
                       : sel_trim ? trim_rd
                       : sel_cfg ? cfg_rd
                       : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // ======================================================
    // Postscaled system clock enable
    osc_postscaler u_post (
        .pclk(pclk),
        .presetn(presetn),
        .sel(ctl_q.clk_postscale_sel),
        .clk_en(sys_clk_en)
    );

    // ======================================================
    // Clock selection outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sel <= '0;
            switch_enabled <= 1'b0;
            monitor_enabled <= 1'b0;
        end else begin
            clk_sel.group <= (sw_q == osc_ctrl_pkg::SW_BUSY)
                             ? ctl_q.next_clk_group
                             : ctl_q.current_clk_group;
            clk_sel.primary_osc_select <= pri_select;
            clk_sel.switch_start <= (sw_q == osc_ctrl_pkg::SW_BUSY);
            clk_sel.secondary_osc_enable <= ctl_q.secondary_osc_enable;
            clk_sel.fast_rc_trim <= trim_q;
            switch_enabled <= sw_on;
            monitor_enabled <= mon_on;
        end
    end
endmodule

// ==== hdl/osc_ctrl_cfg.svh ====
// Purpose: Offsets, field positions, keys, reset values and counts
// Assumes: APB byte addressing, one 32-bit word per register
// Notes: Definitions only
`ifndef OSC_CTRL_CFG_SVH
`define OSC_CTRL_CFG_SVH
// ==========================================================
// Register byte offsets
`define OSC_CTRL_OFS 12'h000
`define FRC_TRIM_OFS 12'h004
`define OSC_CFG_OFS 12'h008
// ==========================================================
// Control register fields
`define CUR_GRP_LSB 12
`define NXT_GRP_LSB 8
`define POST_LSB 6
`define LOCK_BIT 5
`define CF_BIT 3
`define SOSC_BIT 1
`define REQ_BIT 0
// ==========================================================
// Configuration word fields
`define SWMON_LSB 14
`define PON_GRP_LSB 8
`define PRI_SEL_LSB 0
// ==========================================================
// Unlock keys
`define LO_KEY1 8'h46
`define LO_KEY2 8'h57
`define HI_KEY1 8'h78
`define HI_KEY2 8'h9A
// ==========================================================
// Group codes and reset values
`define GRP_FRC 3'h1
`define GRP_RST 3'h0
`define POST_RST 2'h0
`define TRIM_RST 4'h0
`define CFG_RST 24'h00C000
// ==========================================================
// Timing counts
`define SYNC_SETTLE 2'h3
`define DIV_BY_4 6'h03
`define DIV_BY_16 6'h0F
`define DIV_BY_64 6'h3F
`endif

// ==== hdl/osc_ctrl_pkg.sv ====
// Purpose: Types shared by the oscillator control files
// Assumes: Constants live in osc_ctrl_cfg.svh
// Notes: Nothing here is imported; use osc_ctrl_pkg::name
package osc_ctrl_pkg;
    // ======================================================
    // Unlock sequence states
    typedef enum logic [1:0] {
        LK_IDLE,
        LK_KEY1,
        LK_OPEN
    } unlock_e;
    // ======================================================
    // Clock switch states
    typedef enum logic [0:0] {
        SW_IDLE,
        SW_BUSY
    } switch_e;
    // ======================================================
    // Control register contents
    typedef struct packed {
        logic [2:0] current_clk_group;
        logic [2:0] next_clk_group;
        logic [1:0] clk_postscale_sel;
        logic clk_fail_flag;
        logic secondary_osc_enable;
        logic clk_switch_request;
    } osc_ctrl_s;
    // ======================================================
    // Clock selection sent to the clock multiplexer
    typedef struct packed {
        logic [2:0] group;
        logic [4:0] primary_osc_select;
        logic switch_start;
        logic secondary_osc_enable;
        logic [3:0] fast_rc_trim;
    } clk_sel_s;
endpackage

// ==== hdl/osc_postscaler.sv ====
// Purpose: Divides the system clock rate into an enable pulse
// Assumes: Selection changes take effect at once; the count is compared with the new limit
// Notes: Code 00 gives an enable every cycle
`timescale 1ns/1ps
`include "osc_ctrl_cfg.svh"
module osc_postscaler (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] sel,
    output logic clk_en
);
    logic [5:0] cnt_q;
    logic [5:0] limit;

    // ======================================================
    // Division limits
    always_comb begin
        case (sel)
            2'h3: limit = `DIV_BY_64;
            2'h2: limit = `DIV_BY_16;
            2'h1: limit = `DIV_BY_4;
            default: limit = 6'h00;
        endcase
    end

    wire wrap = (cnt_q >= limit);
    assign clk_en = wrap;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 6'h00;
        end else begin
            cnt_q <= wrap ? 6'h00 : cnt_q + 6'h01;
        end
    end
endmodule

// ==== hdl/osc_unlock_seq.sv ====
// Purpose: Two-key unlock for one byte lane of the control register
// Assumes: Events come from completed APB accesses
// Notes: Any completed access that breaks the pattern restarts it
`timescale 1ns/1ps
module osc_unlock_seq #(
    parameter logic [7:0] KEY1 = 8'h00,
    parameter logic [7:0] KEY2 = 8'h00
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic access,
    input wire logic lane_write,
    input wire logic [7:0] lane_data,
    output logic commit
);
    osc_ctrl_pkg::unlock_e state_q, state_d;
    wire key1_hit = lane_write && (lane_data == KEY1);
    wire key2_hit = lane_write && (lane_data == KEY2);

    // ======================================================
    // Window is open for exactly one access after the pair
    assign commit = access && lane_write
                    && (state_q == osc_ctrl_pkg::LK_OPEN);

    always_comb begin
        state_d = state_q;
        if (access) begin
            case (state_q)
                osc_ctrl_pkg::LK_IDLE: begin
                    state_d = key1_hit ? osc_ctrl_pkg::LK_KEY1
                                       : osc_ctrl_pkg::LK_IDLE;
                end
                osc_ctrl_pkg::LK_KEY1: begin
                    state_d = key2_hit ? osc_ctrl_pkg::LK_OPEN
                                       : osc_ctrl_pkg::LK_IDLE;
                end
                default: begin
                    state_d = osc_ctrl_pkg::LK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= osc_ctrl_pkg::LK_IDLE;
        end else begin
            state_q <= state_d;
        end
    end
endmodule
